// >>> rtl/fbc_defs.svh
// Constants for the flash bus command host: offsets, fields, commands, timing
// Notes on behaviour
// - Word read: power pin high, selects and OE low, WE high; WE low writes.
// - Byte mode: low byte only; OE high disables; a high select is standby.
// - Lowest active address bit: low gives maker code, high device code.
// - Host keeps other address bits zero while reading identifier codes.
// - After 90H, the next two reads return maker code then device code.
// - After B0H during erase, host confirms the suspended bit reads 1.
// - If suspend found no erase, host resumes with D0H after next erase.
// - With suspend in use, erase is issued as 20H, D0H at block, then D0H.
`ifndef FBC_DEFS_SVH
`define FBC_DEFS_SVH

`define FBC_CLK_PS        5000
`define FBC_NS2CYC(ns)    ((((ns) * 1000) + `FBC_CLK_PS - 1) / `FBC_CLK_PS)
`define FBC_T_SU_NS       20
`define FBC_T_WP_NS       50
`define FBC_T_HOLD_NS     20
`define FBC_T_ACC_NS      150
`define FBC_T_GAP_NS      30
`define FBC_T_BUSY_NS     100
`define FBC_T_RECOVER_NS  480

`define FBC_REG_CTRL      8'h00
`define FBC_REG_ADDR      8'h04
`define FBC_REG_WDATA     8'h08
`define FBC_REG_CMD       8'h0C
`define FBC_REG_STATUS    8'h10
`define FBC_REG_RDATA0    8'h14
`define FBC_REG_RDATA1    8'h18

`define FBC_CTRL_PD       0
`define FBC_CTRL_WORD     1
`define FBC_CTRL_VPP      2

`define FBC_CMD_READ_ARR  16'h00FF
`define FBC_CMD_IDENT     16'h0090
`define FBC_CMD_STATUS    16'h0070
`define FBC_CMD_CLEAR     16'h0050
`define FBC_CMD_WRITE     16'h0040
`define FBC_CMD_ERASE     16'h0020
`define FBC_CMD_CONFIRM   16'h00D0
`define FBC_CMD_SUSPEND   16'h00B0

`define FBC_CSR_READY     7
`define FBC_CSR_SUSP      6
`define FBC_CSR_ES        5
`define FBC_CSR_DWS       4
`define FBC_CSR_VPPS      3

`endif

// >>> rtl/fbc_pkg.sv
// Types for the flash bus command host
package fbc_pkg;

  typedef enum logic [3:0] {
    FBC_OP_READ_ARRAY,
    FBC_OP_READ_ID,
    FBC_OP_READ_STATUS,
    FBC_OP_CLEAR_STATUS,
    FBC_OP_DATA_WRITE,
    FBC_OP_BLOCK_ERASE,
    FBC_OP_SUSPEND,
    FBC_OP_RESUME,
    FBC_OP_POLL
  } fbc_op_t;

  typedef enum logic [2:0] {
    FBC_ST_IDLE,
    FBC_ST_RECOVER,
    FBC_ST_SETUP,
    FBC_ST_STROBE,
    FBC_ST_READ,
    FBC_ST_HOLD,
    FBC_ST_GAP,
    FBC_ST_WAIT_RDY
  } fbc_state_t;

  typedef struct packed {
    logic        rd;
    logic        last;
    logic        use_addr;
    logic        ident;
    logic        id_bit;
    logic [15:0] data;
  } fbc_step_t;

endpackage

// >>> rtl/fbc_host.sv
// Host controller driving a flash part through its asynchronous bus pins
`timescale 1ns/1ps
`default_nettype none
`include "fbc_defs.svh"

module fbc_host
  import fbc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output var  logic [31:0] reg_rdata_o,
  output var  logic        power_down_reset_n_o,
  output var  logic        chip_select_first_n_o,
  output var  logic        chip_select_second_n_o,
  output var  logic        flash_oe_n_o,
  output var  logic        flash_we_n_o,
  output var  logic        flash_word_mode_o,
  output var  logic        flash_vpp_high_o,
  output var  logic [20:0] flash_addr_o,
  input  wire logic [15:0] flash_dq_i,
  output var  logic [15:0] flash_dq_o,
  output var  logic [1:0]  flash_dq_oe_o,
  input  wire logic        ready_busy_n_i
);

  localparam logic [7:0] SU_CYC   = 8'(`FBC_NS2CYC(`FBC_T_SU_NS));
  localparam logic [7:0] WP_CYC   = 8'(`FBC_NS2CYC(`FBC_T_WP_NS));
  localparam logic [7:0] HOLD_CYC = 8'(`FBC_NS2CYC(`FBC_T_HOLD_NS));
  localparam logic [7:0] ACC_CYC  = 8'(`FBC_NS2CYC(`FBC_T_ACC_NS));
  localparam logic [7:0] GAP_CYC  = 8'(`FBC_NS2CYC(`FBC_T_GAP_NS));
  localparam logic [7:0] BUSY_CYC = 8'(`FBC_NS2CYC(`FBC_T_BUSY_NS));
  localparam logic [7:0] REC_CYC  = 8'(`FBC_NS2CYC(`FBC_T_RECOVER_NS));

  // One bus cycle of a command sequence, chosen by operation and position
  function automatic fbc_step_t step_of(input fbc_op_t    op,
                                        input logic [1:0] idx,
                                        input logic [15:0] wd);
    fbc_step_t s;
    s = '{rd: 1'b0, last: 1'b1, use_addr: 1'b0, ident: 1'b0,
          id_bit: 1'b0, data: 16'h0000};
    case (op)
      FBC_OP_READ_ARRAY: begin
        s.data     = `FBC_CMD_READ_ARR;
        s.last     = (idx != 2'h0);
        s.rd       = (idx != 2'h0);
        s.use_addr = 1'b1;
      end
      FBC_OP_READ_ID: begin
        s.data   = `FBC_CMD_IDENT;
        s.rd     = (idx != 2'h0);
        s.ident  = 1'b1;
        s.id_bit = (idx == 2'h2);
        s.last   = (idx == 2'h2);
      end
      FBC_OP_READ_STATUS: begin
        s.data = `FBC_CMD_STATUS;
        s.rd   = (idx != 2'h0);
        s.last = (idx != 2'h0);
      end
      FBC_OP_CLEAR_STATUS: begin
        s.data = `FBC_CMD_CLEAR;
      end
      FBC_OP_DATA_WRITE: begin
        s.data     = (idx == 2'h0) ? `FBC_CMD_WRITE : wd;
        s.use_addr = (idx != 2'h0);
        s.last     = (idx != 2'h0);
      end
      FBC_OP_BLOCK_ERASE: begin
        s.data     = (idx == 2'h0) ? `FBC_CMD_ERASE : `FBC_CMD_CONFIRM;
        s.use_addr = (idx == 2'h1);
        s.last     = (idx == 2'h2);
      end
      FBC_OP_SUSPEND: begin
        s.data = `FBC_CMD_SUSPEND;
      end
      FBC_OP_RESUME: begin
        s.data = `FBC_CMD_CONFIRM;
      end
      FBC_OP_POLL: begin
        s.rd = 1'b1;
      end
      default: begin
        s.last = 1'b1;
      end
    endcase
    return s;
  endfunction

  // Identifier reads keep every address bit but the lowest active one at zero
  function automatic logic [20:0] pin_addr(input fbc_step_t   s,
                                           input logic [20:0] a,
                                           input logic        word);
    logic [20:0] r;
    r = 21'h000000;
    if (s.ident) begin
      if (word) begin
        r[1] = s.id_bit;
      end else begin
        r[0] = s.id_bit;
      end
    end else if (s.use_addr) begin
      r = word ? {a[20:1], 1'b0} : a;
    end
    return r;
  endfunction

  fbc_state_t  state_q;
  fbc_op_t     op_q;
  fbc_op_t     post_q;
  logic [1:0]  idx_q;
  logic [7:0]  cnt_q;
  logic [2:0]  ctrl_q;
  logic [20:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata0_q;
  logic [15:0] rdata1_q;
  logic [7:0]  csr_q;
  logic        suspended_q;
  logic        owed_q;
  logic [2:0]  rb_sync_q;
  logic        rb_q;
  logic [15:0] dq_s1_q;
  logic [15:0] dq_s2_q;
  logic [15:0] dq_s3_q;
  fbc_step_t   cur;
  logic        start;
  logic [15:0] dq_in;
  logic        dq_stable;

  assign cur       = step_of(op_q, idx_q, wdata_q);
  assign start     = reg_we_i && (reg_addr_i == `FBC_REG_CMD) &&
                     (state_q == FBC_ST_IDLE) && !ctrl_q[`FBC_CTRL_PD];
  assign dq_stable = (dq_s2_q == dq_s3_q);
  // Byte mode carries data on the low byte only
  assign dq_in     = ctrl_q[`FBC_CTRL_WORD] ? dq_s3_q : {8'h00, dq_s3_q[7:0]};

  // Pin synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rb_sync_q <= 3'h0;
      rb_q      <= 1'b0;
      dq_s1_q   <= 16'h0000;
      dq_s2_q   <= 16'h0000;
      dq_s3_q   <= 16'h0000;
    end else begin
      rb_sync_q <= {rb_sync_q[1:0], ready_busy_n_i};
      if (rb_sync_q[1] == rb_sync_q[2]) begin
        rb_q <= rb_sync_q[2];
      end
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  // Software-written control and operands
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q  <= 3'h0;
      addr_q  <= 21'h000000;
      wdata_q <= 16'h0000;
    end else if (reg_we_i) begin
      case (reg_addr_i)
        `FBC_REG_CTRL:  ctrl_q  <= reg_wdata_i[2:0];
        `FBC_REG_ADDR:  addr_q  <= reg_wdata_i[20:0];
        `FBC_REG_WDATA: wdata_q <= reg_wdata_i[15:0];
        default: begin
        end
      endcase
    end
  end

  // Register read port, data in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        `FBC_REG_CTRL:   reg_rdata_o <= {29'h00000000, ctrl_q};
        `FBC_REG_ADDR:   reg_rdata_o <= {11'h000, addr_q};
        `FBC_REG_WDATA:  reg_rdata_o <= {16'h0000, wdata_q};
        `FBC_REG_STATUS: reg_rdata_o <= {16'h0000, csr_q, 3'h0,
                                         |csr_q[`FBC_CSR_ES:`FBC_CSR_VPPS],
                                         owed_q, suspended_q, rb_q,
                                         state_q != FBC_ST_IDLE};
        `FBC_REG_RDATA0: reg_rdata_o <= {16'h0000, rdata0_q};
        `FBC_REG_RDATA1: reg_rdata_o <= {16'h0000, rdata1_q};
        default:         reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  // Static pin levels follow the control register
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      power_down_reset_n_o <= 1'b0;
      flash_word_mode_o    <= 1'b0;
      flash_vpp_high_o     <= 1'b0;
    end else begin
      power_down_reset_n_o <= !ctrl_q[`FBC_CTRL_PD];
      flash_word_mode_o    <= ctrl_q[`FBC_CTRL_WORD];
      // Without the high supply the part flags failure instead of finishing
      flash_vpp_high_o     <= ctrl_q[`FBC_CTRL_VPP];
    end
  end

  // Command sequencer and bus cycle timing
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q                <= FBC_ST_RECOVER;
      op_q                   <= FBC_OP_READ_ARRAY;
      post_q                 <= FBC_OP_READ_ARRAY;
      idx_q                  <= 2'h0;
      cnt_q                  <= REC_CYC;
      chip_select_first_n_o  <= 1'b1;
      chip_select_second_n_o <= 1'b1;
      flash_oe_n_o           <= 1'b1;
      flash_we_n_o           <= 1'b1;
      flash_addr_o           <= 21'h000000;
      flash_dq_o             <= 16'h0000;
      flash_dq_oe_o          <= 2'h0;
      rdata0_q               <= 16'h0000;
      rdata1_q               <= 16'h0000;
      csr_q                  <= 8'h00;
      suspended_q            <= 1'b0;
      owed_q                 <= 1'b0;
    end else if (ctrl_q[`FBC_CTRL_PD]) begin
      // Power-down aborts the part's work and wipes its status
      state_q                <= FBC_ST_RECOVER;
      cnt_q                  <= REC_CYC;
      chip_select_first_n_o  <= 1'b1;
      chip_select_second_n_o <= 1'b1;
      flash_oe_n_o           <= 1'b1;
      flash_we_n_o           <= 1'b1;
      flash_dq_oe_o          <= 2'h0;
      csr_q                  <= 8'h00;
      suspended_q            <= 1'b0;
      owed_q                 <= 1'b0;
    end else begin
      case (state_q)
        FBC_ST_RECOVER: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            state_q <= FBC_ST_IDLE;
          end
        end
        FBC_ST_IDLE: begin
          if (start) begin
            op_q    <= fbc_op_t'({1'b0, reg_wdata_i[2:0]});
            post_q  <= fbc_op_t'({1'b0, reg_wdata_i[2:0]});
            idx_q   <= 2'h0;
            cnt_q   <= SU_CYC;
            state_q <= FBC_ST_SETUP;
          end
        end
        FBC_ST_SETUP: begin
          flash_addr_o           <= pin_addr(cur, addr_q,
                                             ctrl_q[`FBC_CTRL_WORD]);
          chip_select_first_n_o  <= 1'b0;
          chip_select_second_n_o <= 1'b0;
          flash_dq_o             <= cur.data;
          flash_dq_oe_o          <= cur.rd ? 2'h0 :
                                    {ctrl_q[`FBC_CTRL_WORD], 1'b1};
          flash_oe_n_o           <= !cur.rd;
          cnt_q                  <= cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            if (cur.rd) begin
              cnt_q   <= ACC_CYC;
              state_q <= FBC_ST_READ;
            end else begin
              flash_we_n_o <= 1'b0;
              cnt_q        <= WP_CYC;
              state_q      <= FBC_ST_STROBE;
            end
          end
        end
        FBC_ST_STROBE: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            flash_we_n_o <= 1'b1;
            cnt_q        <= HOLD_CYC;
            state_q      <= FBC_ST_HOLD;
          end
        end
        FBC_ST_READ: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (dq_stable) begin
            if (op_q == FBC_OP_POLL || op_q == FBC_OP_READ_STATUS) begin
              csr_q <= dq_in[7:0];
            end
            if (op_q == FBC_OP_READ_ID && idx_q == 2'h2) begin
              rdata1_q <= dq_in;
            end else begin
              rdata0_q <= dq_in;
            end
            flash_oe_n_o <= 1'b1;
            cnt_q        <= HOLD_CYC;
            state_q      <= FBC_ST_HOLD;
          end
        end
        FBC_ST_HOLD: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            chip_select_first_n_o  <= 1'b1;
            chip_select_second_n_o <= 1'b1;
            flash_dq_oe_o          <= 2'h0;
            cnt_q                  <= GAP_CYC;
            state_q                <= FBC_ST_GAP;
          end
        end
        FBC_ST_GAP: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            if (!cur.last) begin
              idx_q   <= idx_q + 2'h1;
              cnt_q   <= SU_CYC;
              state_q <= FBC_ST_SETUP;
            end else begin
              case (op_q)
                FBC_OP_DATA_WRITE, FBC_OP_BLOCK_ERASE, FBC_OP_SUSPEND: begin
                  cnt_q   <= BUSY_CYC;
                  state_q <= FBC_ST_WAIT_RDY;
                end
                FBC_OP_POLL: begin
                  state_q <= FBC_ST_IDLE;
                  if (post_q == FBC_OP_SUSPEND) begin
                    if (csr_q[`FBC_CSR_SUSP]) begin
                      suspended_q <= 1'b1;
                    end else begin
                      owed_q <= 1'b1;
                    end
                  end else if (post_q == FBC_OP_BLOCK_ERASE && owed_q) begin
                    // Resume owed from a suspend that found no erase
                    op_q    <= FBC_OP_RESUME;
                    idx_q   <= 2'h0;
                    cnt_q   <= SU_CYC;
                    state_q <= FBC_ST_SETUP;
                  end
                end
                FBC_OP_RESUME: begin
                  suspended_q <= 1'b0;
                  owed_q      <= 1'b0;
                  state_q     <= FBC_ST_IDLE;
                end
                default: begin
                  state_q <= FBC_ST_IDLE;
                end
              endcase
            end
          end
        end
        FBC_ST_WAIT_RDY: begin
          // Pin is read with OE high; its level holds whatever OE does
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (rb_q) begin
            op_q    <= FBC_OP_POLL;
            idx_q   <= 2'h0;
            cnt_q   <= SU_CYC;
            state_q <= FBC_ST_SETUP;
          end
        end
        default: begin
          state_q <= FBC_ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> dv/fbc_host_chk.sv
// Checker for the flash host pins and control register
`timescale 1ns/1ps
`default_nettype none
`include "fbc_defs.svh"
module fbc_host_chk (
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        power_down_reset_n_o,
  input  wire logic        chip_select_first_n_o,
  input  wire logic        chip_select_second_n_o,
  input  wire logic        flash_oe_n_o,
  input  wire logic        flash_we_n_o,
  input  wire logic        flash_word_mode_o,
  input  wire logic        flash_vpp_high_o,
  input  wire logic [20:0] flash_addr_o,
  input  wire logic [15:0] flash_dq_o,
  input  wire logic [1:0]  flash_dq_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  logic [2:0] ctrl_w_q;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i)
      ctrl_w_q <= 3'h0;
    else if (reg_we_i && reg_addr_i == `FBC_REG_CTRL)
      ctrl_w_q <= reg_wdata_i[2:0];
  end
  property p_sel_pair;
    chip_select_first_n_o == chip_select_second_n_o;
  endproperty
  a_sel_pair: assert property (p_sel_pair)
    else $error("selects differ");
  property p_oe_we;
    !(!flash_oe_n_o && !flash_we_n_o);
  endproperty
  a_oe_we: assert property (p_oe_we)
    else $error("read and write strobes both low");
  property p_write_cycle;
    !flash_we_n_o |-> !chip_select_first_n_o && flash_dq_oe_o != 2'b00
      && $stable(flash_dq_o);
  endproperty
  a_write_cycle: assert property (p_write_cycle)
    else $error("write strobe without selected, driven data");
  property p_no_fight;
    flash_dq_oe_o != 2'b00 |-> flash_oe_n_o;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("data driven while part outputs enabled");
  property p_byte_lane;
    !flash_word_mode_o |-> !flash_dq_oe_o[1];
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("high byte driven in byte mode");
  property p_pd_quiet;
    !power_down_reset_n_o |-> chip_select_first_n_o && flash_dq_oe_o == 2'b00;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("bus active in power-down");
  property p_ctrl_pins;
    reg_we_i && reg_addr_i == `FBC_REG_CTRL |-> ##2
      {flash_vpp_high_o, flash_word_mode_o, !power_down_reset_n_o} == ctrl_w_q;
  endproperty
  a_ctrl_pins: assert property (p_ctrl_pins)
    else $error("control pins do not follow control register");
  property p_we_width;
    $fell(flash_we_n_o) |-> ##10 !flash_we_n_o ##1 flash_we_n_o;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe width wrong");
  property p_addr_hold;
    !chip_select_first_n_o && $past(!chip_select_first_n_o)
      |-> $stable(flash_addr_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved inside a bus cycle");
endmodule
bind fbc_host fbc_host_chk u_chk (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
  .power_down_reset_n_o(power_down_reset_n_o),
  .chip_select_first_n_o(chip_select_first_n_o),
  .chip_select_second_n_o(chip_select_second_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
  .flash_word_mode_o(flash_word_mode_o), .flash_vpp_high_o(flash_vpp_high_o),
  .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
  .flash_dq_oe_o(flash_dq_oe_o)
);
`default_nettype wire

// >>> dv/fbc_flash_model.sv
// Behavioural flash part answering the host bus cycles
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model #(
  parameter logic [15:0] MAKER_ID = 16'h1357, // Arbitrary value
  parameter logic [15:0] DEV_ID   = 16'h2468  // Arbitrary value
) (
  input  wire logic        power_down_reset_n_i,
  input  wire logic        chip_select_first_n_i,
  input  wire logic        chip_select_second_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        word_i,
  input  wire logic        vpp_i,
  input  wire logic [20:0] addr_i,
  input  wire logic [15:0] dq_i,
  output var  logic [15:0] dq_o,
  output var  logic        pull_low_o
);
  logic [15:0] mem [int];
  logic [7:0]  compat_status_reg = 8'h00;
  logic [1:0]  mode = 2'd0;
  logic        pend_w = 1'b0;
  logic        pend_e = 1'b0;
  logic        busy = 1'b0;
  logic        slow = 1'b0;
  logic        sel;
  logic        drive;
  logic [15:0] val;
  logic [15:0] last = 16'h0000;
  event        go;
  assign sel = power_down_reset_n_i && !chip_select_first_n_i
    && !chip_select_second_n_i;
  assign drive = sel && !oe_n_i && we_n_i;
  // Alternate short and long operations to vary the answer time
  always begin : engine
    @(go);
    busy = 1'b1;
    #(slow ? 2000 : 150);
    busy = 1'b0;
    slow = !slow;
  end
  assign pull_low_o = busy && power_down_reset_n_i;
  always @(posedge we_n_i) begin
    if (sel && (pend_w || pend_e)) begin
      if (!vpp_i)
        compat_status_reg = compat_status_reg | (pend_w ? 8'h18 : 8'h28);
      else if (pend_w)
        mem[int'(addr_i[20:1])] = dq_i;
      else if (dq_i[7:0] == 8'hD0)
        mem.delete();
      mode = 2'd2;
      pend_w = 1'b0;
      pend_e = 1'b0;
      -> go;
    end else if (sel) begin
      case (dq_i[7:0])
        8'hFF: mode = 2'd0;
        8'h90: mode = 2'd1;
        8'h70, 8'hB0: mode = 2'd2;
        8'h50: compat_status_reg = compat_status_reg & 8'hC7;
        8'h40, 8'h10: pend_w = 1'b1;
        8'h20: pend_e = 1'b1;
        default: ;
      endcase
    end
  end
  always @(negedge power_down_reset_n_i) begin
    disable engine;
    busy = 1'b0;
    compat_status_reg = 8'h00;
    mode = 2'd0;
    pend_w = 1'b0;
    pend_e = 1'b0;
  end
  always @* begin
    case (mode)
      2'd1: val = ((word_i ? addr_i[1] : addr_i[0]) ? DEV_ID : MAKER_ID)
        ^ {16{|(addr_i & (word_i ? 21'h1FFFFD : 21'h1FFFFE))}};
      2'd2: val = {8'h00, !busy, compat_status_reg[6:0]};
      default: val = mem.exists(int'(addr_i[20:1]))
        ? mem[int'(addr_i[20:1])] : 16'hFFFF;
    endcase
    if (!word_i)
      val = {8'h00, (mode == 2'd0 && addr_i[0]) ? val[15:8]
        : val[7:0]};
    if (drive)
      last = val;
  end
  // Released bus shows the inverse of the last value
  assign dq_o = drive ? val : ~last;
endmodule
`default_nettype wire

// >>> dv/flash_bus_command_interface_bench.sv
// Self-checking bench for the flash host against the flash part model
`timescale 1ns/1ps
`default_nettype none
`include "fbc_defs.svh"
module flash_bus_command_interface_bench;
  localparam logic [15:0] MAKER = 16'h1357; // Arbitrary value
  localparam logic [15:0] DEV   = 16'h2468; // Arbitrary value
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic [31:0] rdata, v;
  logic        pd_n, sel1_n, sel2_n, oe_n, we_n, word, vpp, pull_low, rb_n;
  logic [20:0] faddr;
  logic [15:0] dq_h, dq_f, dq_w;
  logic [1:0]  dq_oe;
  logic        saw_busy = 1'b0;
  int          failures = 0;
  int          checks = 0;
  always #2.5 clk = !clk;
  assign rb_n = !pull_low;
  assign dq_w = {dq_oe[1] ? dq_h[15:8] : 8'hFF, dq_oe[0] ? dq_h[7:0] : 8'hFF};
  always @(posedge clk) if (!rb_n) saw_busy <= 1'b1;
  fbc_host uut (
    .clk_sys_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .power_down_reset_n_o(pd_n),
    .chip_select_first_n_o(sel1_n), .chip_select_second_n_o(sel2_n),
    .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_word_mode_o(word),
    .flash_vpp_high_o(vpp), .flash_addr_o(faddr), .flash_dq_i(dq_f),
    .flash_dq_o(dq_h), .flash_dq_oe_o(dq_oe), .ready_busy_n_i(rb_n)
  );
  fbc_flash_model #(.MAKER_ID(MAKER), .DEV_ID(DEV)) part (
    .power_down_reset_n_i(pd_n), .chip_select_first_n_i(sel1_n),
    .chip_select_second_n_i(sel2_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .word_i(word), .vpp_i(vpp), .addr_i(faddr), .dq_i(dq_w),
    .dq_o(dq_f), .pull_low_o(pull_low)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d failures", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask
  // Slow part operations take about 400 cycles; the bound leaves margin
  task automatic wait_idle();
    for (int i = 0; i < 600; i++) begin
      rd(`FBC_REG_STATUS, v);
      if (v[0] === 1'b0)
        return;
    end
    chk(v, 32'h0);
    give_verdict();
  endtask
  task automatic run(input logic [2:0] op);
    wr(`FBC_REG_CMD, {29'h0, op});
    wait_idle();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    wait_idle();
    wr(`FBC_REG_CTRL, 32'h6);
    rd_chk(`FBC_REG_CTRL, 32'h6);
    rd_chk(8'h40, 32'h0);
    chk({28'h0, pd_n, word, vpp, sel1_n}, 32'hF);
    $display("Test control done");
    run(3'd1);
    rd_chk(`FBC_REG_RDATA0, {16'h0, MAKER});
    rd_chk(`FBC_REG_RDATA1, {16'h0, DEV});
    wr(`FBC_REG_CTRL, 32'h4);
    run(3'd1);
    rd_chk(`FBC_REG_RDATA0, {24'h0, MAKER[7:0]});
    rd_chk(`FBC_REG_RDATA1, {24'h0, DEV[7:0]});
    $display("Test identifier done");
    wr(`FBC_REG_CTRL, 32'h6);
    wr(`FBC_REG_ADDR, 32'h1234);
    wr(`FBC_REG_WDATA, 32'hBEEF);
    run(3'd4);
    chk({31'h0, saw_busy}, 32'h1);
    rd(`FBC_REG_STATUS, v);
    chk(v & 32'hFF1F, 32'h8002);
    run(3'd0);
    rd_chk(`FBC_REG_RDATA0, 32'hBEEF);
    $display("Test data write done");
    wr(`FBC_REG_CTRL, 32'h2);
    wr(`FBC_REG_ADDR, 32'h2000);
    run(3'd4);
    rd(`FBC_REG_STATUS, v);
    chk(v & 32'hFF1F, 32'h9812);
    run(3'd0);
    rd_chk(`FBC_REG_RDATA0, 32'hFFFF);
    run(3'd3);
    run(3'd2);
    rd_chk(`FBC_REG_RDATA0, 32'h80);
    $display("Test supply and clear done");
    wr(`FBC_REG_CTRL, 32'h6);
    run(3'd6);
    rd(`FBC_REG_STATUS, v);
    chk(v & 32'hC, 32'h8);
    wr(`FBC_REG_ADDR, 32'h1234);
    run(3'd5);
    rd(`FBC_REG_STATUS, v);
    chk(v & 32'hC, 32'h0);
    run(3'd0);
    rd_chk(`FBC_REG_RDATA0, 32'hFFFF);
    run(3'd6);
    run(3'd7);
    rd(`FBC_REG_STATUS, v);
    chk(v & 32'hC, 32'h0);
    $display("Test suspend and erase done");
    wr(`FBC_REG_CTRL, 32'h2);
    // Power down mid-write, so the abort is really exercised
    wr(`FBC_REG_CMD, 32'h4);
    repeat (100) @(posedge clk);
    chk({31'h0, rb_n}, 32'h0);
    wr(`FBC_REG_CTRL, 32'h3);
    repeat (3) @(posedge clk);
    chk({30'h0, pd_n, rb_n}, 32'h1);
    rd(`FBC_REG_STATUS, v);
    chk(v & 32'hFF1C, 32'h0);
    wr(`FBC_REG_CTRL, 32'h2);
    wait_idle();
    run(3'd2);
    rd_chk(`FBC_REG_RDATA0, 32'h80);
    $display("Test power-down done");
    give_verdict();
  end
endmodule
`default_nettype wire
